// >>> common/ltc_pkg.sv
// Constants, types and helpers shared by the light threshold configuration block.
// Assumes a register port driven by the two-wire serial front end on the same clock.
package ltc_pkg;

    // ==================================================================
    // Widths
    // ==================================================================
    localparam int WORD_W  = 16;               // Register word width
    localparam int ADDR_W  = 8;                // Register pointer width
    localparam int EXP_W   = 4;                // Exponent width
    localparam int MAN_W   = 12;               // Mantissa width
    localparam int LIN_W   = 27;               // Mantissa shifted by up to 15
    localparam int FCNT_W  = 4;                // Consecutive fault counter width

    // ==================================================================
    // Register offsets
    // ==================================================================
    localparam logic [7:0] OFS_RESULT    = 8'h00; // Result register, masked view
    localparam logic [7:0] OFS_CONFIG    = 8'h01; // Configuration subset
    localparam logic [7:0] OFS_LOW_LIMIT = 8'h02; // Lower threshold

    // ==================================================================
    // Field positions
    // ==================================================================
    localparam int EXP_MSB   = 15;             // Exponent field, upper nibble
    localparam int EXP_LSB   = 12;
    localparam int MAN_MSB   = 11;             // Mantissa field
    localparam int MAN_LSB   = 0;
    localparam int CFG_RANGE_MSB = 15;         // Range select in configuration
    localparam int CFG_RANGE_LSB = 12;
    localparam int CFG_LATCH_BIT = 4;          // Unused bit, reads as one
    localparam int CFG_MASK_BIT  = 2;          // Exponent mask enable
    localparam int CFG_FC_MSB    = 1;          // Fault count select
    localparam int CFG_FC_LSB    = 0;

    // ==================================================================
    // Codes and reset values
    // ==================================================================
    localparam logic [3:0]  RANGE_AUTO      = 4'hc;   // Automatic full-scale ranging
    localparam logic [3:0]  RANGE_RESET     = 4'hc;   // Range select after reset
    localparam logic [3:0]  MAX_EXP         = 4'hb;   // Largest meaningful exponent
    localparam logic [3:0]  ZERO_EXP        = 4'h0;   // Masked exponent value
    localparam logic [3:0]  LOW_EXP_RESET   = 4'h0;
    localparam logic [11:0] LOW_MAN_RESET   = 12'h000;
    localparam logic        MASK_RESET      = 1'b0;
    localparam logic [1:0]  FC_RESET        = 2'h0;
    localparam logic [1:0]  FC_ONE          = 2'h0;
    localparam logic [1:0]  FC_TWO          = 2'h1;
    localparam logic [1:0]  FC_FOUR         = 2'h2;
    localparam logic [3:0]  NEED_ONE        = 4'h1;
    localparam logic [3:0]  NEED_TWO        = 4'h2;
    localparam logic [3:0]  NEED_FOUR       = 4'h4;
    localparam logic [3:0]  NEED_EIGHT      = 4'h8;
    localparam logic [15:0] WORD_ZERO       = 16'h0000;

    // ==================================================================
    // State types
    // ==================================================================
    typedef struct packed {
        logic [3:0]  low_exp;                  // Low-limit exponent
        logic [11:0] low_man;                  // Low-limit mantissa
        logic        mask_en;                  // Exponent mask enable
        logic [1:0]  fc_sel;                   // Fault count select
        logic [3:0]  range_sel;                // Range select
        logic [15:0] rdata;                    // Read answer
        logic [15:0] result;                   // Presented result word
    } ltc_regs_st_t;

    typedef struct packed {
        logic [3:0] count;                     // Consecutive faults seen
        logic       ind;                       // Threshold indicator
    } ltc_fcnt_st_t;

    // ==================================================================
    // Helpers
    // ==================================================================
    // Faults needed before an indicator sets
    function automatic logic [3:0] ltc_faults_needed(input logic [1:0] sel);
        logic [3:0] n;
        n = NEED_EIGHT;
        case (sel)
            FC_ONE:  n = NEED_ONE;
            FC_TWO:  n = NEED_TWO;
            FC_FOUR: n = NEED_FOUR;
            default: n = NEED_EIGHT;
        endcase
        return n;
    endfunction

    // Exponent/mantissa to linear counts of 0.01 lux
    function automatic logic [26:0] ltc_linear(input logic [3:0] e, input logic [11:0] m);
        logic [3:0] ec;
        ec = (e > MAX_EXP) ? MAX_EXP : e;
        return 27'(m) << ec;
    endfunction

endpackage

// >>> design/ltc_fault_cnt.sv
// Consecutive fault counter driving one threshold indicator.
// Assumes conversion pulses and fault levels come from logic on the same clock.
`timescale 1ns/1ps
module ltc_fault_cnt (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic       conv_done,
    input  wire logic       fault,
    input  wire logic [1:0] fc_sel,
    output logic            ind
);
    import ltc_pkg::*;

    ltc_fcnt_st_t st_ff;                       // Registered state
    ltc_fcnt_st_t nxt_st;                      // Next state
    logic [3:0]   need;                        // Faults required now

    // ==================================================================
    // Next state
    // ==================================================================
    // Saturate at the need so a later change of select stays sane
    always_comb begin
        nxt_st = st_ff;
        need   = ltc_faults_needed(fc_sel);     // [R4] [R12]
        if (clk_en && conv_done) begin
            if (fault) begin                   // Out of limit: advance [R3] [R12]
                if (st_ff.count < need) begin
                    nxt_st.count = st_ff.count + 4'h1;
                end
                nxt_st.ind = ((st_ff.count + 4'h1) >= need);
            end else begin                     // In limit: streak broken [R12]
                nxt_st.count = 4'h0;
                nxt_st.ind   = 1'b0;
            end
        end
    end

    // State register, frozen while clock enable is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ind = st_ff.ind;

    // ==================================================================
    // Checks
    // ==================================================================
    a_ind_cause: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
        $rose(st_ff.ind) |-> $past(clk_en && conv_done && fault))
        else $error("indicator rose without a fault");
    a_ind_clear: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
        (clk_en && conv_done && !fault) |=> (!st_ff.ind && st_ff.count == 4'h0))
        else $error("good conversion did not clear streak");
    a_two_faults: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
        (fc_sel == FC_TWO && st_ff.count == 4'h0 && clk_en && conv_done && fault) |=> !st_ff.ind)
        else $error("two-fault select set after one fault");
    a_one_fault: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
        (fc_sel == FC_ONE && clk_en && conv_done && fault) |=> st_ff.ind)
        else $error("one-fault select did not set");
    c_ind_set: cover property (@(posedge clk) disable iff (!rst_n) $rose(st_ff.ind));
endmodule

// >>> design/ltc_regs.sv
// Threshold configuration registers of an ambient light sensor.
// Assumes the serial front end issues single-cycle read and write strobes
// with a pointer, and the conversion engine pulses once per finished result.
//
// Notes on behaviour
// [R1] Mask on, manual range: result exponent zero
// [R2] Masking touches only the presented result
// [R3] Fault select sets consecutive faults before flags
// [R4] Codes 00/01/10 mean 1/2/4; resets 00
// [R5] Low-limit register, read/write, offset 02h
// [R6] Bits 15:12 exponent, read/write, reset zero
// [R7] Bits 11:0 mantissa, read/write, reset zero
// [R8] Threshold equals 0.01 times 2^exp times mantissa; exponents above 11 clamp to 11 here
// [R9] Under flag: below low limit, streak long
// [R10] Over flag: above high limit, streak long
// [R11] Range code 1100b automatic, lower manual
// [R12] Code 11 means eight; count per conversion
`timescale 1ns/1ps
module ltc_regs (
    input  wire logic                        CORE_CLK,
    input  wire logic                        RST_N,
    input  wire logic                        CLK_EN,
    input  wire logic [ltc_pkg::ADDR_W-1:0]  REG_ADDR,
    input  wire logic                        REG_WR,
    input  wire logic                        REG_RD,
    input  wire logic [ltc_pkg::WORD_W-1:0]  REG_WDATA,
    input  wire logic                        CONV_DONE,
    input  wire logic [ltc_pkg::EXP_W-1:0]   CONV_EXPONENT,
    input  wire logic [ltc_pkg::MAN_W-1:0]   CONV_MANTISSA,
    input  wire logic [ltc_pkg::WORD_W-1:0]  HIGH_LIMIT,
    output logic      [ltc_pkg::WORD_W-1:0]  REG_RDATA,
    output logic      [ltc_pkg::WORD_W-1:0]  RESULT_VIEW,
    output logic      [ltc_pkg::EXP_W-1:0]   RANGE_SELECT,
    output logic                             OVER_THRESHOLD_IND,
    output logic                             UNDER_THRESHOLD_IND
);
    import ltc_pkg::*;

    // ==================================================================
    // Declarations
    // ==================================================================
    ltc_regs_st_t st_ff;                       // Registered state
    ltc_regs_st_t nxt_st;                      // Next state
    logic [26:0]  conv_lin;                    // Unmasked result, linear
    logic [26:0]  low_lin;                     // Low limit, linear
    logic [26:0]  high_lin;                    // High limit, linear
    logic         under_fault;                 // Result below low limit
    logic         over_fault;                  // Result above high limit
    logic         manual_range;                // Range chosen by software
    logic [15:0]  cfg_word;                    // Configuration read image

    // ==================================================================
    // Threshold comparison
    // ==================================================================
    // Compare on raw conversion data so masking never shifts a threshold
    // Exponents clamp at eleven, so the linear value always fits 27 bits
    always_comb begin
        conv_lin    = ltc_linear(CONV_EXPONENT, CONV_MANTISSA);              // [R2] [R8]
        low_lin     = ltc_linear(st_ff.low_exp, st_ff.low_man);              // [R8]
        high_lin    = ltc_linear(HIGH_LIMIT[EXP_MSB:EXP_LSB], HIGH_LIMIT[MAN_MSB:MAN_LSB]);
        under_fault = (conv_lin < low_lin);                                  // [R9]
        over_fault  = (conv_lin > high_lin);                                 // [R10]
    end

    // ==================================================================
    // Register file
    // ==================================================================
    // Writes, reads and the presented result; all frozen without clock enable
    // Limitation: read and write of one pointer in one cycle return the old word
    always_comb begin
        nxt_st       = st_ff;
        manual_range = (st_ff.range_sel < RANGE_AUTO);                       // [R11]
        cfg_word     = WORD_ZERO;
        cfg_word[CFG_RANGE_MSB:CFG_RANGE_LSB] = st_ff.range_sel;
        cfg_word[CFG_LATCH_BIT]               = 1'b1;                        // Unused bit reads one
        cfg_word[CFG_MASK_BIT]                = st_ff.mask_en;
        cfg_word[CFG_FC_MSB:CFG_FC_LSB]       = st_ff.fc_sel;
        if (CLK_EN) begin
            // Register writes
            if (REG_WR) begin
                case (REG_ADDR)
                    OFS_CONFIG: begin
                        nxt_st.range_sel = REG_WDATA[CFG_RANGE_MSB:CFG_RANGE_LSB];
                        nxt_st.mask_en   = REG_WDATA[CFG_MASK_BIT];
                        nxt_st.fc_sel    = REG_WDATA[CFG_FC_MSB:CFG_FC_LSB];   // [R3]
                    end
                    OFS_LOW_LIMIT: begin                                     // [R5]
                        nxt_st.low_exp = REG_WDATA[EXP_MSB:EXP_LSB];         // [R6]
                        nxt_st.low_man = REG_WDATA[MAN_MSB:MAN_LSB];         // [R7]
                    end
                    default: begin
                        // Result is read-only; other pointers ignored
                    end
                endcase
            end
            // Register reads, answer held until the next read
            if (REG_RD) begin
                case (REG_ADDR)
                    OFS_RESULT:    nxt_st.rdata = st_ff.result;
                    OFS_CONFIG:    nxt_st.rdata = cfg_word;
                    OFS_LOW_LIMIT: nxt_st.rdata = {st_ff.low_exp, st_ff.low_man};  // [R5]
                    default:       nxt_st.rdata = WORD_ZERO;
                endcase
            end
            // Presented result, exponent forced to zero when masking is on and range is manual
            if (CONV_DONE) begin
                if (st_ff.mask_en && manual_range) begin
                    nxt_st.result = {ZERO_EXP, CONV_MANTISSA};               // [R1]
                end else begin
                    nxt_st.result = {CONV_EXPONENT, CONV_MANTISSA};          // [R2]
                end
            end
        end
    end

    // State register
    // Reset branch loads constants only, so no logic can feed it
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_ff.low_exp   <= LOW_EXP_RESET;                                // [R6]
            st_ff.low_man   <= LOW_MAN_RESET;                                // [R7]
            st_ff.mask_en   <= MASK_RESET;
            st_ff.fc_sel    <= FC_RESET;                                     // [R4]
            st_ff.range_sel <= RANGE_RESET;
            st_ff.rdata     <= WORD_ZERO;
            st_ff.result    <= WORD_ZERO;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign REG_RDATA    = st_ff.rdata;
    assign RESULT_VIEW  = st_ff.result;
    assign RANGE_SELECT = st_ff.range_sel;

    // ==================================================================
    // Indicator streak counters
    // ==================================================================
    // Same counter for both sides; the fault term picks the limit
    ltc_fault_cnt u_over (
        .clk       (CORE_CLK),
        .rst_n     (RST_N),
        .clk_en    (CLK_EN),
        .conv_done (CONV_DONE),
        .fault     (over_fault),                                             // [R10]
        .fc_sel    (st_ff.fc_sel),
        .ind       (OVER_THRESHOLD_IND)
    );

    ltc_fault_cnt u_under (
        .clk       (CORE_CLK),
        .rst_n     (RST_N),
        .clk_en    (CLK_EN),
        .conv_done (CONV_DONE),
        .fault     (under_fault),                                            // [R9]
        .fc_sel    (st_ff.fc_sel),
        .ind       (UNDER_THRESHOLD_IND)
    );

    // ==================================================================
    // Checks
    // ==================================================================
    a_mask_zero_exp: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R1]
        (CLK_EN && CONV_DONE && st_ff.mask_en && st_ff.range_sel < RANGE_AUTO)
        |=> RESULT_VIEW[EXP_MSB:EXP_LSB] == ZERO_EXP)
        else $error("masked exponent not zero");
    a_auto_keeps_exp: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R11]
        (CLK_EN && CONV_DONE && st_ff.range_sel >= RANGE_AUTO)
        |=> RESULT_VIEW == {$past(CONV_EXPONENT), $past(CONV_MANTISSA)})
        else $error("auto range result altered");
    a_raw_compare: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R2]
        (CONV_DONE && CONV_EXPONENT >= st_ff.low_exp && CONV_MANTISSA >= st_ff.low_man)
        |-> !under_fault)
        else $error("low compare not on raw data");
    a_low_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R6]
        (CLK_EN && REG_WR && REG_ADDR == OFS_LOW_LIMIT)
        |=> {st_ff.low_exp, st_ff.low_man} == $past(REG_WDATA))
        else $error("low limit write lost");
    a_low_readback: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R5]
        (CLK_EN && REG_RD && !REG_WR && REG_ADDR == OFS_LOW_LIMIT)
        |=> REG_RDATA == {st_ff.low_exp, st_ff.low_man})
        else $error("low limit readback wrong");
    a_fc_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R3]
        (CLK_EN && REG_WR && REG_ADDR == OFS_CONFIG)
        |=> st_ff.fc_sel == $past(REG_WDATA[CFG_FC_MSB:CFG_FC_LSB]))
        else $error("fault select write lost");
    a_under_one: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R9]
        (CLK_EN && CONV_DONE && under_fault && st_ff.fc_sel == FC_ONE) |=> UNDER_THRESHOLD_IND)
        else $error("under indicator missed");
    a_eight_faults: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R12]
        (st_ff.fc_sel == 2'h3 && u_over.st_ff.count < 4'h7 && !OVER_THRESHOLD_IND && CLK_EN && CONV_DONE && over_fault
         && !REG_WR) |=> !OVER_THRESHOLD_IND)
        else $error("eight-fault select set too soon");
    a_freeze: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R7]
        !CLK_EN |=> $stable(st_ff))
        else $error("state moved with clock enable low");

    // ==================================================================
    // Register port, result and indicator checks
    // ==================================================================
    // Answer must stand between reads; the host may fetch it late
    a_rdata_holds: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R5]
        !(CLK_EN && REG_RD) |=> $stable(REG_RDATA))
        else $error("read answer moved without a read");
    a_range_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R11]
        (CLK_EN && REG_WR && REG_ADDR == OFS_CONFIG)
        |=> RANGE_SELECT == $past(REG_WDATA[CFG_RANGE_MSB:CFG_RANGE_LSB]))
        else $error("range select write lost");
    a_result_ro: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R2]
        (CLK_EN && REG_WR && REG_ADDR == OFS_RESULT && !CONV_DONE)
        |=> $stable(RESULT_VIEW))
        else $error("result word took a write");
    a_mask_keeps_man: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R1]
        (CLK_EN && CONV_DONE)
        |=> RESULT_VIEW[MAN_MSB:MAN_LSB] == $past(CONV_MANTISSA))
        else $error("mantissa altered by masking");
    a_under_clear: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // [R9]
        (CLK_EN && CONV_DONE && !under_fault) |=> !UNDER_THRESHOLD_IND)
        else $error("under indicator kept on in limit");
    // Coverage of the main scenarios
    c_masked: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
        CLK_EN && CONV_DONE && st_ff.mask_en && st_ff.range_sel < RANGE_AUTO);
    c_over: cover property (@(posedge CORE_CLK) disable iff (!RST_N) $rose(OVER_THRESHOLD_IND));
    c_under: cover property (@(posedge CORE_CLK) disable iff (!RST_N) $rose(UNDER_THRESHOLD_IND));
endmodule

// >>> tb/ltc_host_model.sv
// Serial host model: issues register reads and writes as single-cycle strobes.
// Assumes the block samples strobes on the rising CORE_CLK edge and answers one cycle later.
`timescale 1ns/1ps
module ltc_host_model (
    input  wire logic        CORE_CLK,
    output logic [7:0]       REG_ADDR,
    output logic             REG_WR,
    output logic             REG_RD,
    output logic [15:0]      REG_WDATA,
    input  wire logic [15:0] REG_RDATA
);
    // ==================================================================
    // Idle values
    // ==================================================================
    initial begin
        REG_ADDR  = 8'h00;          // Pointer idle
        REG_WR    = 1'b0;           // No write
        REG_RD    = 1'b0;           // No read
        REG_WDATA = 16'h0000;       // Data idle
    end

    // ==================================================================
    // Transfers
    // ==================================================================
    // One write strobe; pointer and data scrambled after release so stale values never pass
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge CORE_CLK);
        REG_ADDR  <= a;
        REG_WDATA <= d;
        REG_WR    <= 1'b1;
        @(posedge CORE_CLK);
        REG_WR    <= 1'b0;
        REG_ADDR  <= ~a;
        REG_WDATA <= ~d;
    endtask

    // One read strobe; answer taken just after the taking edge
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        @(posedge CORE_CLK);
        REG_RD   <= 1'b0;
        REG_ADDR <= ~a;
        #1;
        d = REG_RDATA;
    endtask
endmodule

// >>> tb/ltc_regs_tb.sv
// Self-checking bench for the threshold configuration registers.
// Assumes the host model drives the register port and the bench plays the conversion engine.
`timescale 1ns/1ps
module ltc_regs_tb;
    import ltc_pkg::*;

    // ==================================================================
    // Signals
    // ==================================================================
    logic        clk;              // 250 MHz core clock
    logic        rst_n;            // Asynchronous reset, active low
    logic        clk_en;           // Clock enable
    logic [7:0]  reg_addr;         // Host pointer
    logic        reg_wr;           // Host write strobe
    logic        reg_rd;           // Host read strobe
    logic [15:0] reg_wdata;        // Host write data
    logic [15:0] reg_rdata;        // Read answer
    logic        conv_done;        // Conversion pulse
    logic [3:0]  conv_exp;         // Raw exponent
    logic [11:0] conv_man;         // Raw mantissa
    logic [15:0] high_limit;       // High-limit word
    logic [15:0] result_view;      // Presented result
    logic [3:0]  range_sel;        // Range select out
    logic        over_ind;         // Over indicator
    logic        under_ind;        // Under indicator
    logic [15:0] rv;               // Last read value
    int          n_mismatch;       // Mismatch counter
    int          check_count;      // Comparison counter

    // ==================================================================
    // Instances
    // ==================================================================
    ltc_regs DUT (.CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en), .REG_ADDR(reg_addr),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .CONV_DONE(conv_done),
        .CONV_EXPONENT(conv_exp), .CONV_MANTISSA(conv_man), .HIGH_LIMIT(high_limit),
        .REG_RDATA(reg_rdata), .RESULT_VIEW(result_view), .RANGE_SELECT(range_sel),
        .OVER_THRESHOLD_IND(over_ind), .UNDER_THRESHOLD_IND(under_ind));

    ltc_host_model host (.CORE_CLK(clk), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata));

    // ==================================================================
    // Clock and watchdog
    // ==================================================================
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Hard cap well above the length of the main sequence
    initial begin
        #40000;
        n_mismatch++;
        final_report();
    end

    // ==================================================================
    // Helpers
    // ==================================================================
    // Compare and count; four-state inequality so unknowns fail
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One conversion pulse; outputs looked at after the taking edge
    task automatic conv(input logic [3:0] e, input logic [11:0] m);
        @(posedge clk);
        conv_done <= 1'b1;
        conv_exp  <= e;
        conv_man  <= m;
        @(posedge clk);
        conv_done <= 1'b0;
        conv_exp  <= ~e;
        conv_man  <= ~m;
        #1;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ==================================================================
    // Main sequence
    // ==================================================================
    initial begin
        n_mismatch  = 0;
        check_count = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        conv_done = 1'b0;
        conv_exp = 4'h0;
        conv_man = 12'h000;
        high_limit = 16'hffff;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;

        // Reset values and access kinds
        host.rd(8'h02, rv); chk("low reset", 16'h0000, rv);
        host.rd(8'h01, rv); chk("cfg reset", 16'hc010, rv);
        chk("range reset", 16'h000c, {12'h000, range_sel});
        host.wr(8'h02, 16'ha5c3); host.rd(8'h02, rv); chk("low rw", 16'ha5c3, rv);
        host.wr(8'h00, 16'h1234); host.rd(8'h00, rv); chk("result ro", 16'h0000, rv);
        host.rd(8'h07, rv); chk("unmapped", 16'h0000, rv);
        @(posedge clk); clk_en <= 1'b0;
        host.wr(8'h02, 16'h0f0f);
        @(posedge clk); clk_en <= 1'b1;
        host.rd(8'h02, rv); chk("low frozen", 16'ha5c3, rv);
        $display("test registers done");

        // Threshold scaling by exponent: 8 x 16 = 128
        host.wr(8'h02, 16'h3010);
        conv(4'h0, 12'h07f); chk("under 127", 16'h0001, {15'h0, under_ind});
        conv(4'h0, 12'h080); chk("under 128", 16'h0000, {15'h0, under_ind});
        conv(4'h2, 12'h01f); chk("under 124", 16'h0001, {15'h0, under_ind});
        $display("test scaling done");

        // Masking: manual range hides the exponent, comparisons keep raw data
        host.wr(8'h01, 16'h3004); host.rd(8'h01, rv); chk("cfg rw", 16'h3014, rv);
        chk("range out", 16'h0003, {12'h000, range_sel});
        conv(4'h4, 12'h020); chk("masked view", 16'h0020, result_view);
        chk("raw compare", 16'h0000, {15'h0, under_ind});
        host.rd(8'h00, rv); chk("masked read", 16'h0020, rv);
        host.wr(8'h01, 16'hc004);
        conv(4'h4, 12'h020); chk("auto view", 16'h4020, result_view);
        host.wr(8'h01, 16'h3000);
        conv(4'h4, 12'h020); chk("unmasked view", 16'h4020, result_view);
        $display("test masking done");

        // Every fault count code: 1, 2, 4, 8 consecutive faults
        host.wr(8'h02, 16'h0100);
        for (int fc = 0; fc < 4; fc++) begin
            host.wr(8'h01, 16'hc000 | 16'(fc));
            host.rd(8'h01, rv); chk("cfg fc", 16'hc010 | 16'(fc), rv);
            conv(4'h0, 12'h200);
            for (int i = 0; i < (1 << fc); i++) begin
                conv(4'h0, 12'h010);
                chk("under streak", 16'(i == (1 << fc) - 1), {15'h0, under_ind});
            end
            conv(4'h0, 12'h200); chk("under clear", 16'h0000, {15'h0, under_ind});
            chk("over quiet", 16'h0000, {15'h0, over_ind});
        end
        $display("test fault count done");

        // Over indicator against the high limit, 2 x 256 = 512
        host.wr(8'h01, 16'hc000);
        high_limit <= 16'h1100;
        conv(4'h2, 12'h100); chk("over set", 16'h0001, {15'h0, over_ind});
        conv(4'h1, 12'h100); chk("over equal", 16'h0000, {15'h0, over_ind});
        $display("test over done");

        final_report();
    end
endmodule
